// ---- dram_16k_by_1_interface_tb.sv ----
`timescale 1ns/1ps
module dram_16k_by_1_interface_tb;
   import dram_pkg::*;
   localparam int GAP = 40;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic REQ_VALID = 1'b0;
   logic REQ_WRITE = 1'b0;
   logic REQ_PAGE = 1'b0;
   logic [CELL_BITS-1:0] REQ_ADDR = 14'h0000;
   logic REQ_DATA = 1'b0;
   logic REQ_READY, RD_VALID, RD_DATA, ROW_STROBE_N, COLUMN_STROBE_N, WRITE_ENABLE_N, DATA_IN, DATA_OUT, drive, q;
   logic [ROW_BITS-1:0] MUXED_ADDRESS_PINS, cur_row;
   logic [ROWS-1:0] refreshed;
   logic prev_ras, prev_cas, col_seen, wr_seen, at_edge;
   int n_errors = 0, checks_done = 0, ras_gap, cas_hi, we_since, n_ref = 0, n_acc = 0;
   always #(CLK_PERIOD_NS / 2) CLK = ~CLK;
   dram_ctrl #(.REF_GAP(GAP)) dut_u (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
      .REQ_PAGE(REQ_PAGE), .REQ_ADDR(REQ_ADDR), .REQ_DATA(REQ_DATA), .REQ_READY(REQ_READY),
      .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .MUXED_ADDRESS_PINS(MUXED_ADDRESS_PINS),
      .ROW_STROBE_N(ROW_STROBE_N), .COLUMN_STROBE_N(COLUMN_STROBE_N), .WRITE_ENABLE_N(WRITE_ENABLE_N),
      .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT));
   dram_model mem_u (.addr(MUXED_ADDRESS_PINS), .row_strobe_n(ROW_STROBE_N), .column_strobe_n(COLUMN_STROBE_N),
      .write_enable_n(WRITE_ENABLE_N), .data_in(DATA_IN), .data_out(DATA_OUT), .drive(drive));
   task automatic check(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   always @(negedge CLK) begin
      if (RST) begin
         prev_ras = 1'b1;
         prev_cas = 1'b1;
         ras_gap = RC_CYC;
         cas_hi = CP_CYC;
      end else begin
         ras_gap++;
         we_since = (!WRITE_ENABLE_N && prev_ras === ROW_STROBE_N && wr_seen) ? we_since + 1 : we_since;
         if (prev_ras && !ROW_STROBE_N) begin
            check(ras_gap >= RC_CYC, "cycle starts too close");
            ras_gap = 0;
            col_seen = 1'b0;
            wr_seen = 1'b0;
            cur_row = MUXED_ADDRESS_PINS;
         end
         if (!ROW_STROBE_N && !WRITE_ENABLE_N && !wr_seen) begin
            wr_seen = 1'b1;
            we_since = 1;
         end
         if (prev_cas && !COLUMN_STROBE_N) begin
            if (col_seen) check(cas_hi >= CP_CYC, "page precharge short");
            col_seen = 1'b1;
         end
         if (!prev_ras && ROW_STROBE_N) begin
            if (wr_seen) check(we_since >= RWL_CYC, "write lead short");
            if (col_seen) n_acc++;
            else refreshed[cur_row] = 1'b1;
            if (!col_seen) n_ref++;
         end
         if (drive && (!WRITE_ENABLE_N || (ROW_STROBE_N && COLUMN_STROBE_N))) check(1'b0, "output driven");
         cas_hi = COLUMN_STROBE_N ? cas_hi + 1 : 0;
         prev_ras = ROW_STROBE_N;
         prev_cas = COLUMN_STROBE_N;
      end
   end
   task automatic req(input logic w, input logic pg, input logic [CELL_BITS-1:0] a, input logic d, input logic more);
      int n;
      if (!at_edge) @(posedge CLK);
      REQ_VALID <= 1'b1;
      REQ_WRITE <= w;
      REQ_PAGE <= pg;
      REQ_ADDR <= a;
      REQ_DATA <= d;
      n = 0;
      do begin @(negedge CLK); n++; end while (REQ_READY !== 1'b1 && n < 300);
      check(n < 300, "request not taken");
      @(posedge CLK);
      if (!more) REQ_VALID <= 1'b0;
      // A read returns off the clock edge, so the next request waits for one.
      at_edge = more && w;
      if (!w) begin
         n = 0;
         do begin @(negedge CLK); n++; end while (RD_VALID !== 1'b1 && n < 300);
         q = RD_DATA;
         check(n < 300 && q === d, "read data wrong");
      end
   endtask
   task automatic t_basic();
      logic [CELL_BITS-1:0] adr [4] = '{14'h0080, 14'h0001, 14'h3fff, 14'h2a55};
      logic dat [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
      foreach (adr[i]) req(1'b1, 1'b0, adr[i], dat[i], 1'b0);
      foreach (adr[i]) req(1'b0, 1'b0, adr[i], dat[i], 1'b0);
      $display("basic done");
   endtask
   task automatic t_page();
      int a0;
      int r0;
      a0 = n_acc;
      r0 = n_ref;
      for (int c = 0; c < 4; c++) req(1'b1, 1'b1, {7'h33, 7'(c * 5)}, c[0], c < 3);
      // Wait until the open row has closed, so that it is counted.
      repeat (3 * RC_CYC) @(negedge CLK);
      check(n_acc - a0 >= 1 && n_acc - a0 <= 1 + n_ref - r0, "row sent again in page");
      for (int c = 0; c < 4; c++) req(1'b0, 1'b1, {7'h33, 7'(c * 5)}, c[0], c < 3);
      $display("page done");
   endtask
   task automatic t_refresh();
      refreshed = '0;
      repeat (ROWS * GAP + 4 * RC_CYC) @(posedge CLK);
      check(&refreshed, "row missed by refresh");
      $display("refresh done");
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      at_edge = 1'b0;
      repeat (16) @(posedge CLK);
      RST <= 1'b0;
      t_basic();
      t_page();
      t_refresh();
      give_verdict();
   end
   initial begin
      #(CLK_PERIOD_NS * 20000);
      n_errors++;
      give_verdict();
   end
endmodule

// ---- dram_ctrl.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Split 14-bit address into two 7-bit halves.
// - Row half on pins, then row strobe low.
// - After row hold, column half, then column strobe.
// - Page mode keeps row strobe low.
// - Column strobe high for page precharge.
// - Refresh all 128 rows each 2 ms.
// - Refresh with row strobe only pulses.
// - Idle strobes mean data output open.
// - Space cycle starts by random cycle time.
// - Write enable leads row strobe rise.
module dram_ctrl
   import dram_pkg::*;
#(
   parameter int REF_GAP = REF_GAP_CYC
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic REQ_PAGE,
   input wire logic [CELL_BITS-1:0] REQ_ADDR,
   input wire logic REQ_DATA,
   output logic REQ_READY,
   output logic RD_VALID,
   output logic RD_DATA,
   output logic [ROW_BITS-1:0] MUXED_ADDRESS_PINS,
   output logic ROW_STROBE_N,
   output logic COLUMN_STROBE_N,
   output logic WRITE_ENABLE_N,
   output logic DATA_IN,
   input wire logic DATA_OUT
);
   dram_state_type state;
   logic [ROW_BITS-1:0] open_row;
   logic [ROW_BITS-1:0] ref_row;
   logic [15:0] ref_count;
   logic ref_due;
   logic is_refresh;
   logic is_write;
   logic t_load;
   logic [7:0] t_value;
   logic t_done;
   logic [7:0] rc_count;
   logic page_hit;

   function automatic logic [ROW_BITS-1:0] row_of(input logic [CELL_BITS-1:0] a);
      return a[CELL_BITS-1:ROW_BITS];
   endfunction

   dram_timer #(.WIDTH(8)) u_timer (
      .clk(CLK),
      .rst(RST),
      .load(t_load),
      .value(t_value),
      .done(t_done)
   );

   always_comb begin
      page_hit = REQ_VALID && REQ_PAGE && !ref_due && row_of(REQ_ADDR) == open_row;
   end

   // Refresh pacing: one row per gap, so all rows are visited within the interval.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ref_count <= '0;
         ref_due <= 1'b0;
      end else if (ref_count >= 16'(REF_GAP - 1)) begin
         ref_count <= '0;
         ref_due <= 1'b1;
      end else begin
         ref_count <= ref_count + 16'h0001;
         if (state == DRAM_ROW && is_refresh) begin
            ref_due <= 1'b0;
         end
      end
   end

   // Cycle-start spacing counter.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rc_count <= '0;
      end else if (state == DRAM_IDLE && t_done && rc_count == '0 && (REQ_VALID || ref_due)) begin
         rc_count <= 8'(RC_CYC - 1);
      end else if (rc_count != '0) begin
         rc_count <= rc_count - CNT_ONE;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state <= DRAM_IDLE;
         MUXED_ADDRESS_PINS <= '0;
         ROW_STROBE_N <= 1'b1;
         COLUMN_STROBE_N <= 1'b1;
         WRITE_ENABLE_N <= 1'b1;
         DATA_IN <= 1'b0;
         REQ_READY <= 1'b0;
         RD_VALID <= 1'b0;
         RD_DATA <= 1'b0;
         open_row <= '0;
         ref_row <= '0;
         is_refresh <= 1'b0;
         is_write <= 1'b0;
         t_load <= 1'b0;
         t_value <= '0;
      end else begin
         t_load <= 1'b0;
         REQ_READY <= 1'b0;
         RD_VALID <= 1'b0;
         case (state)
            DRAM_IDLE: begin
               if (t_done && rc_count == '0 && ref_due) begin
                  MUXED_ADDRESS_PINS <= ref_row;
                  is_refresh <= 1'b1;
                  state <= DRAM_ROW;
               end else if (t_done && rc_count == '0 && REQ_VALID) begin
                  MUXED_ADDRESS_PINS <= row_of(REQ_ADDR);
                  open_row <= row_of(REQ_ADDR);
                  is_refresh <= 1'b0;
                  state <= DRAM_ROW;
               end
            end
            DRAM_ROW: begin
               // Row half has stood one cycle; now strobe it.
               ROW_STROBE_N <= 1'b0;
               t_load <= 1'b1;
               t_value <= is_refresh ? 8'(RAS_MIN_CYC) : 8'(RCD_CYC);
               state <= is_refresh ? DRAM_END : DRAM_COL;
            end
            DRAM_COL: begin
               if (t_done) begin
                  MUXED_ADDRESS_PINS <= REQ_ADDR[ROW_BITS-1:0];
                  is_write <= REQ_WRITE;
                  DATA_IN <= REQ_DATA;
                  // Write enable before the column strobe makes an early write, output open.
                  WRITE_ENABLE_N <= !REQ_WRITE;
                  REQ_READY <= 1'b1;
                  state <= DRAM_ACC;
               end
            end
            DRAM_ACC: begin
               if (!REQ_READY && COLUMN_STROBE_N) begin
                  COLUMN_STROBE_N <= 1'b0;
                  t_load <= 1'b1;
                  // Waiting the column access also covers the row access on this slow clock.
                  t_value <= 8'(CAC_CYC > RWL_CYC ? CAC_CYC : RWL_CYC);
               end else if (!COLUMN_STROBE_N && t_done) begin
                  RD_VALID <= !is_write;
                  RD_DATA <= DATA_OUT;
                  COLUMN_STROBE_N <= 1'b1;
                  WRITE_ENABLE_N <= 1'b1;
                  t_load <= 1'b1;
                  t_value <= 8'(CP_CYC);
                  state <= DRAM_PRE_COL;
               end
            end
            DRAM_PRE_COL: begin
               if (t_done) begin
                  state <= page_hit ? DRAM_COL : DRAM_END;
               end
            end
            DRAM_END: begin
               if (t_done) begin
                  ROW_STROBE_N <= 1'b1;
                  if (is_refresh) begin
                     ref_row <= ref_row + 7'h01;
                  end
                  t_load <= 1'b1;
                  t_value <= 8'(RP_CYC);
                  state <= DRAM_PRE_ROW;
               end
            end
            DRAM_PRE_ROW: begin
               if (t_done) begin
                  state <= DRAM_IDLE;
               end
            end
            default: begin
               state <= DRAM_IDLE;
            end
         endcase
      end
   end

   a_col_after_row: assert property (@(posedge CLK) disable iff (RST)
      $fell(COLUMN_STROBE_N) |-> !ROW_STROBE_N) else $error("column strobe fell without row strobe");
   a_addr_before_row: assert property (@(posedge CLK) disable iff (RST)
      $fell(ROW_STROBE_N) |-> $stable(MUXED_ADDRESS_PINS)) else $error("row address moved at row strobe");
   a_page_precharge: assert property (@(posedge CLK) disable iff (RST)
      $rose(COLUMN_STROBE_N) |=> COLUMN_STROBE_N [*2]) else $error("column precharge too short");
   // Write enable falls in the column phase, so the row strobe must stay low long enough after it.
   a_write_lead: assert property (@(posedge CLK) disable iff (RST)
      $fell(WRITE_ENABLE_N) |-> (!ROW_STROBE_N) [*2]) else $error("write enable lead before row strobe rise short");
   a_refresh_no_col: assert property (@(posedge CLK) disable iff (RST)
      is_refresh && !ROW_STROBE_N |-> COLUMN_STROBE_N) else $error("refresh pulsed column strobe");
   a_row_precharge: assert property (@(posedge CLK) disable iff (RST)
      $rose(ROW_STROBE_N) |=> ROW_STROBE_N [*3]) else $error("row precharge too short");
   a_early_write: assert property (@(posedge CLK) disable iff (RST)
      $fell(COLUMN_STROBE_N) && is_write |-> !WRITE_ENABLE_N) else $error("write not early");
   a_read_valid: assert property (@(posedge CLK) disable iff (RST)
      RD_VALID |-> !$past(COLUMN_STROBE_N)) else $error("read data outside column strobe");
   a_col_idle: assert property (@(posedge CLK) disable iff (RST)
      ROW_STROBE_N |-> COLUMN_STROBE_N) else $error("column strobe without row");
   c_read: cover property (@(posedge CLK) disable iff (RST) RD_VALID);
   c_refresh: cover property (@(posedge CLK) disable iff (RST) is_refresh && $fell(ROW_STROBE_N));
   c_page: cover property (@(posedge CLK) disable iff (RST) state == DRAM_PRE_COL && page_hit);
endmodule

// ---- dram_model.sv ----
`timescale 1ns/1ps
module dram_model
   import dram_pkg::*;
(
   input wire logic [ROW_BITS-1:0] addr,
   input wire logic row_strobe_n,
   input wire logic column_strobe_n,
   input wire logic write_enable_n,
   input wire logic data_in,
   output logic data_out,
   output logic drive
);
   logic mem [0:ROWS*ROWS-1] = '{default: 1'b0};
   logic [ROW_BITS-1:0] row;
   logic [ROW_BITS-1:0] col;
   realtime t_row = 0;
   int unsigned seq = 0;
   initial begin
      data_out = 1'b0;
      drive = 1'b0;
   end
   always @(negedge row_strobe_n) begin
      row = addr;
      t_row = $realtime;
   end
   task automatic access(input int unsigned s);
      realtime w;
      w = t_row + ACCESS_FROM_ROW_STROBE_NS - $realtime;
      if (w < ACCESS_FROM_COLUMN_STROBE_NS) w = ACCESS_FROM_COLUMN_STROBE_NS;
      #(w);
      if (s == seq && !column_strobe_n) begin
         drive = 1'b1;
         data_out = mem[{row, col}];
      end
   endtask
   always @(negedge column_strobe_n) begin
      col = addr;
      seq = seq + 1;
      if (!write_enable_n) mem[{row, col}] = data_in;
      else fork access(seq); join_none
   end
   always @(negedge write_enable_n) if (!column_strobe_n) mem[{row, col}] = data_in;
   // A released pin shows the inverse so a controller sampling it late reads a wrong bit.
   always @(posedge column_strobe_n) begin
      drive = 1'b0;
      data_out = ~data_out;
   end
endmodule

// ---- dram_pkg.sv ----
package dram_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int ROW_BITS = 7;
   localparam int CELL_BITS = 14;
   localparam int ROWS = 128;
   // Slowest grade figures in ns, refresh interval in ms.
   localparam int RANDOM_CYCLE_TIME_NS = 375;
   localparam int ROW_TO_COLUMN_DELAY_NS = 25;
   localparam int ACCESS_FROM_ROW_STROBE_NS = 200;
   localparam int ACCESS_FROM_COLUMN_STROBE_NS = 135;
   localparam int OUTPUT_RELEASE_DELAY_NS = 50;
   localparam int COLUMN_PRECHARGE_PAGE_NS = 80;
   localparam int WRITE_TO_ROW_LEAD_NS = 70;
   localparam int ROW_PRECHARGE_NS = 120;
   localparam int REFRESH_INTERVAL_MS = 2;
   // Least times round up.
   localparam int RCD_CYC = (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAC_CYC = (ACCESS_FROM_COLUMN_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CP_CYC = (COLUMN_PRECHARGE_PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RWL_CYC = (WRITE_TO_ROW_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RP_CYC = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RC_CYC = (RANDOM_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RAS_MIN_CYC = (ACCESS_FROM_ROW_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Refresh spacing rounds down: 2 ms / 128 rows.
   localparam int REF_GAP_CYC = (REFRESH_INTERVAL_MS * 1000000 / CLK_PERIOD_NS) / ROWS;
   localparam logic [7:0] CNT_ONE = 8'h01;
   typedef enum logic [6:0] {
      DRAM_IDLE = 7'h01, DRAM_ROW = 7'h02, DRAM_COL = 7'h04, DRAM_ACC = 7'h08,
      DRAM_PRE_COL = 7'h10, DRAM_END = 7'h20, DRAM_PRE_ROW = 7'h40
   } dram_state_type;
endpackage

// ---- dram_timer.sv ----
`timescale 1ns/1ps
module dram_timer
   import dram_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [WIDTH-1:0] value,
   output logic done
);
   logic [WIDTH-1:0] count;
   // Done is low during a load even when the count has run out, so a load always restarts it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else if (load) begin
         count <= value;
      end else if (count != '0) begin
         count <= count - WIDTH'(1);
      end
   end
   always_comb begin
      done = (count == '0) && !load;
   end
endmodule
